// *** ddrmr_pkg.sv ***
package ddrmr_pkg;
	localparam int CLK_NS      = 100;
	localparam int T_RESET_NS  = 100;
	localparam int T_CKELO_NS  = 10;
	localparam int T_INIT_US   = 500;
	localparam int T_CKSTAB_NS = 10;
	localparam int T_CKSTAB_CK = 5;
	localparam int T_XPR_CK    = 5;
	localparam int N_RESET     = (T_RESET_NS + CLK_NS - 1) / CLK_NS;
	localparam int N_CKELO     = (T_CKELO_NS + CLK_NS - 1) / CLK_NS;
	localparam int N_INIT      = (T_INIT_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int N_CKSTAB_NS = (T_CKSTAB_NS + CLK_NS - 1) / CLK_NS;
	localparam int N_CKSTAB    = (N_CKSTAB_NS > T_CKSTAB_CK) ? N_CKSTAB_NS : T_CKSTAB_CK;
	localparam int N_XPR       = T_XPR_CK;
	localparam int N_HOLD      = (N_RESET > N_CKELO) ? N_RESET : N_CKELO;

	localparam int ADDR_W = 15;
	localparam int DQ_W   = 8;
	localparam int CNT_W  = 16;

	// command pins as {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_ZQ  = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_DES = 4'hF;

	localparam logic [2:0] BA_MR0 = 3'h0;
	localparam logic [2:0] BA_MR1 = 3'h1;
	localparam logic [2:0] BA_MR2 = 3'h2;
	localparam logic [2:0] BA_MR3 = 3'h3;

	localparam int A_BL_LSB = 0;
	localparam int A_BT     = 3;
	localparam int A_DLLRST = 8;
	localparam int A_DLLDIS = 0;
	localparam int A_AP     = 10;
	localparam int A_BC     = 12;

	localparam logic [1:0] BL_FIX8 = 2'h0;
	localparam logic [1:0] BL_OTF  = 2'h1;
	localparam logic [1:0] BL_FIX4 = 2'h2;

	localparam logic [7:0] REG_CMD  = 8'h00;
	localparam logic [7:0] REG_MR0  = 8'h04;
	localparam logic [7:0] REG_MR1  = 8'h08;
	localparam logic [7:0] REG_MR2  = 8'h0C;
	localparam logic [7:0] REG_MR3  = 8'h10;
	localparam logic [7:0] REG_WD0  = 8'h14;
	localparam logic [7:0] REG_WD1  = 8'h18;
	localparam logic [7:0] REG_RD0  = 8'h1C;
	localparam logic [7:0] REG_RD1  = 8'h20;
	localparam logic [7:0] REG_STAT = 8'h24;

	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_BA_LSB  = 4;
	localparam int CMD_AD_LSB  = 16;
	localparam int ST_READY    = 0;
	localparam int ST_BUSY     = 1;
	localparam int ST_ERR      = 2;
	localparam int ST_RDONE    = 3;
	localparam int ST_OPEN_LSB = 8;

	typedef enum logic [2:0] {OP_NONE, OP_INIT, OP_MRS, OP_ACT, OP_RD, OP_WR, OP_PRE} ddrmr_op_type;

	function automatic logic [2:0] burst_col(input logic [2:0] s, input logic [2:0] b,
			input logic ilv);
		logic [1:0] lo;
		lo = s[1:0] + b[1:0];
		return ilv ? (s ^ b) : {s[2] ^ b[2], lo};
	endfunction

	function automatic logic burst_is8(input logic [1:0] mode, input logic a12);
		return (mode == BL_FIX8) || ((mode == BL_OTF) && a12);
	endfunction

	function automatic logic cnt_done(input logic [15:0] c, input logic [15:0] lim);
		return ({1'b0, c} + 17'h00001) >= {1'b0, lim};
	endfunction

	// load order during initialisation: MR2, MR3, MR1, MR0
	function automatic logic [2:0] init_ba(input logic [1:0] idx);
		case (idx)
			2'h0: return BA_MR2;
			2'h1: return BA_MR3;
			2'h2: return BA_MR1;
			default: return BA_MR0;
		endcase
	endfunction
endpackage

// *** ddrmr_if.sv ***
`timescale 1ns/1ps
interface ddrmr_if;
	logic        reset_n;
	logic        cke;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic [2:0]  ba;
	logic [14:0] addr;
	logic [7:0]  dq_c;
	logic        dq_c_oe_n;
	logic [7:0]  dq_d;
	logic        dq_d_oe_n;
	logic [7:0]  dq;

	// resolved data wire; an undriven bus reads as zero
	assign dq = !dq_c_oe_n ? dq_c : (!dq_d_oe_n ? dq_d : 8'h00);

	modport ctrl (output reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_c, dq_c_oe_n,
		input dq, dq_d_oe_n);
	modport dram (input reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq, dq_c_oe_n,
		output dq_d, dq_d_oe_n);
endinterface

// *** ddrmr_dram.sv ***
`timescale 1ns/1ps
module ddrmr_dram #(
	parameter logic [15:0] P_INIT_CYC = 16'(ddrmr_pkg::N_INIT),
	parameter logic [15:0] P_MRD      = 16'h0004,
	parameter logic [15:0] P_MOD      = 16'h000C
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset,
	ddrmr_if.dram            bus,
	output logic [3:0][14:0] o_mr,
	output logic             o_mr_valid,
	output logic             o_init_done,
	output logic             o_dll_reset,
	output logic             o_err_timing,
	output logic             o_err_state
);
	logic        dev_rst;
	logic        take;
	logic [3:0]  cmd;
	logic        is_mrs;
	logic        is_rw;
	logic        is_other;
	logic        idle;
	logic [15:0] init_cnt_q;
	logic        init_done_q;
	logic [3:0]  mr_set_q;
	logic [15:0] since_q;
	logic [7:0]  open_q;
	logic [7:0]  mem_q [0:63];
	logic        bst_on_q;
	logic        bst_rd_q;
	logic        bst_ilv_q;
	logic [2:0]  bst_start_q;
	logic [2:0]  bst_bank_q;
	logic [2:0]  bst_beat_q;
	logic [2:0]  bst_last_q;
	logic [2:0]  col;
	logic        bl8;

	assign dev_rst  = i_reset || !bus.reset_n;
	assign take     = init_done_q && bus.cke && !bus.cs_n;
	assign cmd      = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
	assign is_mrs   = take && (cmd == ddrmr_pkg::CMD_MRS);
	assign is_rw    = take && ((cmd == ddrmr_pkg::CMD_RD) || (cmd == ddrmr_pkg::CMD_WR));
	assign is_other = take && (cmd != ddrmr_pkg::CMD_MRS) && (cmd != ddrmr_pkg::CMD_NOP);
	assign idle     = (open_q == 8'h00) && !bst_on_q && bus.cke;
	assign col      = ddrmr_pkg::burst_col(bst_start_q, bst_beat_q, bst_ilv_q);
	assign bl8      = ddrmr_pkg::burst_is8(o_mr[0][ddrmr_pkg::A_BL_LSB +: 2],
		bus.addr[ddrmr_pkg::A_BC]);
	assign o_init_done = init_done_q;

	////////////////////////////////////////////////////////////////////////////////
	// internal init runs on our own count; no command is honoured before it ends
	always_ff @(posedge i_ref_clk) begin
		if (dev_rst) begin
			init_cnt_q  <= 16'h0000;
			init_done_q <= 1'b0;
		end else if (!init_done_q) begin
			init_cnt_q <= init_cnt_q + 16'h0001;
			if (ddrmr_pkg::cnt_done(init_cnt_q, P_INIT_CYC)) begin
				init_done_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mode registers change only through MRS; contents meaningless until all set
	always_ff @(posedge i_ref_clk) begin
		if (dev_rst) begin
			o_mr        <= '0;
			mr_set_q    <= 4'h0;
			o_dll_reset <= 1'b0;
			o_mr_valid  <= 1'b0;
		end else begin
			o_dll_reset <= 1'b0;
			o_mr_valid  <= &mr_set_q;
			if (is_mrs && !bus.ba[2]) begin
				o_mr[bus.ba[1:0]]    <= bus.addr;
				mr_set_q[bus.ba[1:0]] <= 1'b1;
				if (bus.ba == ddrmr_pkg::BA_MR0) begin
					// dll reset bit is self clearing
					o_mr[0][ddrmr_pkg::A_DLLRST] <= 1'b0;
					o_dll_reset <= bus.addr[ddrmr_pkg::A_DLLRST];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_ref_clk) begin
		if (dev_rst) begin
			since_q      <= 16'hFFFF;
			o_err_timing <= 1'b0;
			o_err_state  <= 1'b0;
		end else begin
			if (is_mrs) begin
				since_q <= 16'h0000;
			end else if (since_q != 16'hFFFF) begin
				since_q <= since_q + 16'h0001;
			end
			if (is_mrs && !ddrmr_pkg::cnt_done(since_q, P_MRD)) begin
				o_err_timing <= 1'b1;
			end
			if (is_other && !ddrmr_pkg::cnt_done(since_q, P_MOD)) begin
				o_err_timing <= 1'b1;
			end
			if ((is_mrs && !idle) || (bus.cke && !init_done_q) || (is_rw && bst_on_q)) begin
				o_err_state <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_ref_clk) begin
		if (dev_rst) begin
			open_q <= 8'h00;
		end else if (take && (cmd == ddrmr_pkg::CMD_ACT)) begin
			open_q[bus.ba] <= 1'b1;
		end else if (take && (cmd == ddrmr_pkg::CMD_PRE)) begin
			if (bus.addr[ddrmr_pkg::A_AP]) begin
				open_q <= 8'h00;
			end else begin
				open_q[bus.ba] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// one beat per clock; array is never touched by MRS or dll reset
	always_ff @(posedge i_ref_clk) begin
		if (dev_rst) begin
			bst_on_q    <= 1'b0;
			bst_rd_q    <= 1'b0;
			bst_ilv_q   <= 1'b0;
			bst_start_q <= 3'h0;
			bst_bank_q  <= 3'h0;
			bst_beat_q  <= 3'h0;
			bst_last_q  <= 3'h0;
		end else if (is_rw && !bst_on_q) begin
			bst_on_q   <= 1'b1;
			bst_rd_q   <= (cmd == ddrmr_pkg::CMD_RD);
			bst_ilv_q  <= o_mr[0][ddrmr_pkg::A_BT];
			bst_bank_q <= bus.ba;
			bst_beat_q <= 3'h0;
			bst_last_q <= bl8 ? 3'h7 : 3'h3;
			if (cmd == ddrmr_pkg::CMD_RD) begin
				bst_start_q <= bus.addr[2:0];
			end else begin
				bst_start_q <= bl8 ? 3'h0 : {bus.addr[2], 2'h0};
			end
		end else if (bst_on_q) begin
			bst_beat_q <= bst_beat_q + 3'h1;
			if (bst_beat_q == bst_last_q) begin
				bst_on_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (bst_on_q && !bst_rd_q) begin
			mem_q[{bst_bank_q, col}] <= bus.dq;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (dev_rst) begin
			bus.dq_d      <= 8'h00;
			bus.dq_d_oe_n <= 1'b1;
		end else begin
			// chopped reads stop after four beats and release the bus
			bus.dq_d_oe_n <= !(bst_on_q && bst_rd_q);
			bus.dq_d      <= (bst_on_q && bst_rd_q) ? mem_q[{bst_bank_q, col}] : 8'h00;
		end
	end
endmodule

// *** ddrmr_ctrl.sv ***
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
// Summary of operation
// - hold reset low at least 100 ns
// - cke low 10 ns before reset release
// - warm reset reruns whole init flow
// - wait 500 us after reset before cke
// - stable clock and nop before cke
// - wait txpr after cke before first mrs
// - load mr2, mr3, mr1, mr0, then zqcl
// - four mode registers, written only by mrs
// - mode registers undefined until fully written
// - every mrs drives all address fields
// - mrs and dll reset keep array data
// - consecutive mrs spaced by tmrd
// - non-mrs command waits tmod after mrs
// - mrs in normal use only when idle
// - all command pins and banks low select mr0
// - mr0 holds burst, latency, dll fields
// - a3 picks sequential or interleaved burst
// - a1..a0 pick chop four, eight or per-command
// - a12 chooses chop or eight per command
// - read order from start column and type
// - chopped reads four beats; writes aligned start
module ddrmr_ctrl #(
	parameter logic [15:0] P_INIT_CYC = 16'(ddrmr_pkg::N_INIT),
	parameter logic [15:0] P_XPR      = 16'(ddrmr_pkg::N_XPR),
	parameter logic [15:0] P_MRD      = 16'h0004,
	parameter logic [15:0] P_MOD      = 16'h000C,
	parameter logic [15:0] P_ZQDLL    = 16'h0200,
	parameter logic [15:0] P_GAP      = 16'h0004
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	ddrmr_if.ctrl            bus
);
	typedef enum logic [3:0] {S_IDLE, S_RST_HOLD, S_RST_WAIT, S_XPR, S_MRS, S_MRWAIT, S_ZQ,
		S_ZQWAIT, S_READY, S_BURST, S_GAP} ddrmr_st_type;

	ddrmr_st_type          st_q;
	logic [15:0]           cnt_q;
	logic [1:0]            idx_q;
	logic [14:0]           mr_q [0:3];
	logic [63:0]           wd_q;
	logic [63:0]           rd_q;
	logic [7:0]            open_q;
	logic [1:0]            blm_q;
	logic                  wr_q;
	logic [3:0]            beat_q;
	logic [3:0]            nbeat_q;
	logic [15:0]           gap_q;
	logic                  ready_q;
	logic                  err_q;
	logic                  rdone_q;
	logic [3:0]            cmd_q;
	logic                  apb_wr;
	logic                  setup;
	logic                  wr_cmd;
	ddrmr_pkg::ddrmr_op_type op;
	logic [2:0]            c_ba;
	logic [14:0]           c_ad;
	logic                  ok;
	logic                  accept;
	logic                  rd_last;
	logic                  busy;
	logic [2:0]            iba;
	logic [14:0]           iword;
	logic                  c_bl8;

	assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = cmd_q;
	assign setup  = i_psel && !i_penable;
	assign apb_wr = i_psel && i_penable && o_pready && i_pwrite;
	assign wr_cmd = apb_wr && (i_paddr == ddrmr_pkg::REG_CMD);
	assign op     = ddrmr_pkg::ddrmr_op_type'(i_pwdata[ddrmr_pkg::CMD_OP_LSB +: 3]);
	assign c_ba   = i_pwdata[ddrmr_pkg::CMD_BA_LSB +: 3];
	assign c_ad   = i_pwdata[ddrmr_pkg::CMD_AD_LSB +: ddrmr_pkg::ADDR_W];
	assign c_bl8  = ddrmr_pkg::burst_is8(blm_q, c_ad[ddrmr_pkg::A_BC]);
	assign busy   = (st_q != S_IDLE) && (st_q != S_READY);
	assign accept = wr_cmd && ok;
	assign rd_last = (st_q == S_BURST) && !wr_q && !bus.dq_d_oe_n
		&& ((beat_q + 4'h1) == nbeat_q);

	always_comb begin
		ok = 1'b0;
		case (op)
			ddrmr_pkg::OP_INIT: ok = !busy;
			ddrmr_pkg::OP_MRS:  ok = (st_q == S_READY) && (open_q == 8'h00);
			ddrmr_pkg::OP_RD,
			ddrmr_pkg::OP_WR:   ok = (st_q == S_READY) && open_q[c_ba];
			ddrmr_pkg::OP_ACT,
			ddrmr_pkg::OP_PRE:  ok = (st_q == S_READY);
			default:            ok = 1'b0;
		endcase
	end

	// init words: dll enabled in mr1, dll reset requested in mr0
	always_comb begin
		iba   = ddrmr_pkg::init_ba(idx_q);
		iword = mr_q[iba[1:0]];
		if (iba == ddrmr_pkg::BA_MR1) begin
			iword[ddrmr_pkg::A_DLLDIS] = 1'b0;
		end
		if (iba == ddrmr_pkg::BA_MR0) begin
			iword[ddrmr_pkg::A_DLLRST] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait, pready registered from setup, high in the first cycle of the access phase
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h00000000;
			wd_q      <= 64'h0;
			for (int i = 0; i < 4; i++) begin
				mr_q[i] <= 15'h0000;
			end
		end else begin
			o_pready  <= setup;
			o_pslverr <= 1'b0;
			if (setup) begin
				o_prdata <= 32'h00000000;
				case (i_paddr)
					ddrmr_pkg::REG_CMD:  o_prdata <= 32'h00000000;
					ddrmr_pkg::REG_MR0:  o_prdata <= {17'h0, mr_q[0]};
					ddrmr_pkg::REG_MR1:  o_prdata <= {17'h0, mr_q[1]};
					ddrmr_pkg::REG_MR2:  o_prdata <= {17'h0, mr_q[2]};
					ddrmr_pkg::REG_MR3:  o_prdata <= {17'h0, mr_q[3]};
					ddrmr_pkg::REG_WD0:  o_prdata <= wd_q[31:0];
					ddrmr_pkg::REG_WD1:  o_prdata <= wd_q[63:32];
					ddrmr_pkg::REG_RD0:  o_prdata <= rd_q[31:0];
					ddrmr_pkg::REG_RD1:  o_prdata <= rd_q[63:32];
					ddrmr_pkg::REG_STAT: o_prdata <= {16'h0, open_q, 4'h0, rdone_q, err_q,
						busy, ready_q};
					default:             o_pslverr <= 1'b1;
				endcase
			end
			if (apb_wr) begin
				case (i_paddr)
					ddrmr_pkg::REG_MR0: mr_q[0] <= i_pwdata[14:0];
					ddrmr_pkg::REG_MR1: mr_q[1] <= i_pwdata[14:0];
					ddrmr_pkg::REG_MR2: mr_q[2] <= i_pwdata[14:0];
					ddrmr_pkg::REG_MR3: mr_q[3] <= i_pwdata[14:0];
					ddrmr_pkg::REG_WD0: wd_q[31:0] <= i_pwdata;
					ddrmr_pkg::REG_WD1: wd_q[63:32] <= i_pwdata;
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			err_q   <= 1'b0;
			rdone_q <= 1'b0;
		end else begin
			if (wr_cmd && !ok) begin
				err_q <= 1'b1;
			end else if (apb_wr && (i_paddr == ddrmr_pkg::REG_STAT)
					&& i_pwdata[ddrmr_pkg::ST_ERR]) begin
				err_q <= 1'b0;
			end
			if (rd_last) begin
				rdone_q <= 1'b1;
			end else if (apb_wr && (i_paddr == ddrmr_pkg::REG_STAT)
					&& i_pwdata[ddrmr_pkg::ST_RDONE]) begin
				rdone_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer and pins
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			st_q          <= S_IDLE;
			cnt_q         <= 16'h0000;
			idx_q         <= 2'h0;
			bus.reset_n   <= 1'b0;
			bus.cke       <= 1'b0;
			cmd_q         <= ddrmr_pkg::CMD_DES;
			bus.ba        <= 3'h0;
			bus.addr      <= 15'h0000;
			bus.dq_c      <= 8'h00;
			bus.dq_c_oe_n <= 1'b1;
			open_q        <= 8'h00;
			blm_q         <= ddrmr_pkg::BL_FIX8;
			wr_q          <= 1'b0;
			beat_q        <= 4'h0;
			nbeat_q       <= 4'h0;
			gap_q         <= 16'h0000;
			ready_q       <= 1'b0;
			rd_q          <= 64'h0;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			if (bus.reset_n) begin
				cmd_q <= ddrmr_pkg::CMD_NOP;
			end
			case (st_q)
				S_IDLE, S_READY: begin
					if (accept && (op == ddrmr_pkg::OP_INIT)) begin
						// warm reset: full flow again from the top
						st_q        <= S_RST_HOLD;
						cnt_q       <= 16'h0000;
						bus.reset_n <= 1'b0;
						bus.cke     <= 1'b0;
						cmd_q       <= ddrmr_pkg::CMD_DES;
						ready_q     <= 1'b0;
						open_q      <= 8'h00;
					end else if (accept) begin
						bus.ba   <= c_ba;
						bus.addr <= c_ad;
						cnt_q    <= 16'h0000;
						gap_q    <= P_GAP;
						st_q     <= S_GAP;
						beat_q   <= 4'h0;
						nbeat_q  <= c_bl8 ? 4'h8 : 4'h4;
						wr_q     <= (op == ddrmr_pkg::OP_WR);
						case (op)
							ddrmr_pkg::OP_MRS: begin
								cmd_q <= ddrmr_pkg::CMD_MRS;
								gap_q <= P_MOD;
								if (c_ba == ddrmr_pkg::BA_MR0) begin
									blm_q <= c_ad[ddrmr_pkg::A_BL_LSB +: 2];
								end
							end
							ddrmr_pkg::OP_ACT: begin
								cmd_q <= ddrmr_pkg::CMD_ACT;
								open_q[c_ba] <= 1'b1;
							end
							ddrmr_pkg::OP_PRE: begin
								cmd_q <= ddrmr_pkg::CMD_PRE;
								if (c_ad[ddrmr_pkg::A_AP]) begin
									open_q <= 8'h00;
								end else begin
									open_q[c_ba] <= 1'b0;
								end
							end
							ddrmr_pkg::OP_RD: begin
								cmd_q <= ddrmr_pkg::CMD_RD;
								st_q  <= S_BURST;
							end
							default: begin
								cmd_q <= ddrmr_pkg::CMD_WR;
								st_q  <= S_BURST;
							end
						endcase
					end
				end
				S_RST_HOLD: begin
					cmd_q <= ddrmr_pkg::CMD_DES;
					if (ddrmr_pkg::cnt_done(cnt_q, 16'(ddrmr_pkg::N_HOLD))) begin
						bus.reset_n <= 1'b1;
						st_q        <= S_RST_WAIT;
						cnt_q       <= 16'h0000;
					end
				end
				S_RST_WAIT: begin
					// nop on the pins while the clock settles
					// cke waits a full init span after reset_n rose, not one cycle less
					if ((cnt_q >= P_INIT_CYC) && (cnt_q >= 16'(ddrmr_pkg::N_CKSTAB))) begin
						bus.cke <= 1'b1;
						st_q    <= S_XPR;
						cnt_q   <= 16'h0000;
					end
				end
				S_XPR: begin
					if (ddrmr_pkg::cnt_done(cnt_q, P_XPR)) begin
						st_q  <= S_MRS;
						idx_q <= 2'h0;
					end
				end
				S_MRS: begin
					cmd_q    <= ddrmr_pkg::CMD_MRS;
					bus.ba   <= iba;
					bus.addr <= iword;
					st_q     <= S_MRWAIT;
					cnt_q    <= 16'h0000;
					if (iba == ddrmr_pkg::BA_MR0) begin
						blm_q <= iword[ddrmr_pkg::A_BL_LSB +: 2];
					end
				end
				S_MRWAIT: begin
					if (ddrmr_pkg::cnt_done(cnt_q, (idx_q == 2'h3) ? P_MOD : P_MRD)) begin
						idx_q <= idx_q + 2'h1;
						st_q  <= (idx_q == 2'h3) ? S_ZQ : S_MRS;
					end
				end
				S_ZQ: begin
					cmd_q    <= ddrmr_pkg::CMD_ZQ;
					bus.ba   <= 3'h0;
					bus.addr <= 15'h0400;
					st_q     <= S_ZQWAIT;
					cnt_q    <= 16'h0000;
				end
				S_ZQWAIT: begin
					if (ddrmr_pkg::cnt_done(cnt_q, P_ZQDLL)) begin
						st_q    <= S_READY;
						ready_q <= 1'b1;
					end
				end
				S_BURST: begin
					if (wr_q) begin
						if (beat_q < nbeat_q) begin
							bus.dq_c      <= wd_q[{beat_q[2:0], 3'h0} +: 8];
							bus.dq_c_oe_n <= 1'b0;
							beat_q        <= beat_q + 4'h1;
						end else begin
							bus.dq_c_oe_n <= 1'b1;
							st_q          <= S_READY;
						end
					end else if (!bus.dq_d_oe_n) begin
						rd_q[{beat_q[2:0], 3'h0} +: 8] <= bus.dq;
						beat_q <= beat_q + 4'h1;
						if (rd_last) begin
							st_q <= S_READY;
						end
					end
				end
				S_GAP: begin
					if (ddrmr_pkg::cnt_done(cnt_q, gap_q)) begin
						st_q <= S_READY;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule

// *** ddrmr_sva.sv ***
`timescale 1ns/1ps
module ddrmr_sva #(
	parameter logic [15:0] P_INIT_CYC = 16'h0008,
	parameter logic [15:0] P_XPR      = 16'h0005,
	parameter logic [15:0] P_MRD      = 16'h0004,
	parameter logic [15:0] P_MOD      = 16'h000C
) (
	input wire logic        i_ref_clk,
	input wire logic        i_reset,
	input wire logic        reset_n,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [2:0]  ba,
	input wire logic [14:0] addr,
	input wire logic        dq_d_oe_n
);
	localparam int D_MRD = P_MRD + 1;
	localparam int D_MOD = P_MOD + 1;
	logic [3:0]  cmd;
	logic        mrs;
	logic [15:0] rst_q;
	logic [15:0] cke_q;
	logic [15:0] mrs_q;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign mrs = cmd == ddrmr_pkg::CMD_MRS;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	////////////////////////////////////////////////////////////////
	// saturating ages: a wrap would let a late command look early
	always_ff @(posedge i_ref_clk) begin
		rst_q <= (i_reset || !reset_n) ? 16'h0000 : rst_q + {15'h0000, rst_q != 16'hFFFF};
	end
	always_ff @(posedge i_ref_clk) begin
		cke_q <= (i_reset || !cke) ? 16'h0000 : cke_q + {15'h0000, cke_q != 16'hFFFF};
	end
	always_ff @(posedge i_ref_clk) begin
		mrs_q <= (i_reset || !reset_n) ? 16'hFFFF :
			(mrs ? 16'h0000 : mrs_q + {15'h0000, mrs_q != 16'hFFFF});
	end
	////////////////////////////////////////////////////////////////
	sequence s_mrs(b);
		mrs && ba == b;
	endsequence
	a_reset_des: assert property (!reset_n |-> cs_n) else $error("command in reset");
	a_cke_reset: assert property (!reset_n |-> !cke) else $error("cke high in reset");
	a_init_wait: assert property ($rose(cke) |-> rst_q >= P_INIT_CYC)
		else $error("cke raised early");
	a_nop_cke: assert property ($rose(cke) |-> $past(cmd) == ddrmr_pkg::CMD_NOP)
		else $error("no nop before cke");
	a_xpr_wait: assert property (mrs |-> cke_q >= P_XPR && reset_n)
		else $error("mrs too soon after cke");
	a_init_order: assert property (s_mrs(ddrmr_pkg::BA_MR2) ##0 cke_q == P_XPR |->
		##D_MRD s_mrs(ddrmr_pkg::BA_MR3) ##D_MRD s_mrs(ddrmr_pkg::BA_MR1) ##0 !addr[0]
		##D_MRD s_mrs(ddrmr_pkg::BA_MR0) ##0 addr[8]
		##D_MOD (cmd == ddrmr_pkg::CMD_ZQ && addr[10])) else $error("bad init order");
	a_mrd_gap: assert property (mrs |-> mrs_q >= P_MRD) else $error("mrs spacing");
	a_mod_gap: assert property (!cs_n && !mrs && cmd != ddrmr_pkg::CMD_NOP
		|-> mrs_q >= P_MOD) else $error("command inside tmod");
	a_rd_drive: assert property (cmd == ddrmr_pkg::CMD_RD |-> ##2 (!dq_d_oe_n)[*4])
		else $error("read beats missing");
endmodule

// *** test_ddr3_mode_reg_burst_order.sv ***
`timescale 1ns/1ps
module test_ddr3_mode_reg_burst_order;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic             sel = 1'b0;
	logic             en  = 1'b0;
	logic             wr  = 1'b0;
	logic [7:0]       pa  = 8'h00;
	logic [31:0]      pw  = 32'h0;
	logic [31:0]      pr;
	logic [31:0]      q;
	logic             rdy, serr, se, et, es, mv, idn, dr;
	int               dr_count = 0;
	logic [3:0][14:0] mr;
	logic [7:0]       mem [8];
	int               err_count = 0;
	int               check_count = 0;
	ddrmr_if bus_if();
	ddrmr_ctrl #(.P_INIT_CYC(16'h0008), .P_ZQDLL(16'h0004)) ddrmr_ctrl_i (.i_ref_clk(clk),
		.i_reset(rst), .i_psel(sel), .i_penable(en), .i_pwrite(wr), .i_paddr(pa), .i_pwdata(pw),
		.o_prdata(pr), .o_pready(rdy), .o_pslverr(serr), .bus(bus_if));
	ddrmr_dram #(.P_INIT_CYC(16'h0008)) ddrmr_dram_i (.i_ref_clk(clk), .i_reset(rst),
		.bus(bus_if), .o_mr(mr), .o_mr_valid(mv), .o_init_done(idn), .o_dll_reset(dr),
		.o_err_timing(et), .o_err_state(es));
	ddrmr_sva #(.P_INIT_CYC(16'h0008)) ddrmr_sva_i (.i_ref_clk(clk), .i_reset(rst),
		.reset_n(bus_if.reset_n), .cke(bus_if.cke), .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n),
		.cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .ba(bus_if.ba), .addr(bus_if.addr),
		.dq_d_oe_n(bus_if.dq_d_oe_n));
	always #50 clk = ~clk;
	always @(posedge clk) begin
		if (dr === 1'b1) begin
			dr_count++;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		sel <= 1'b1;
		wr <= w;
		pa <= a;
		pw <= d;
		@(posedge clk);
		en <= 1'b1;
		do begin
			@(posedge clk);
		end while (rdy !== 1'b1);
		q = pr;
		se = serr;
		sel <= 1'b0;
		en <= 1'b0;
		@(posedge clk);
	endtask
	// polls status until the bits under m read v, bounded
	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(1'b0, 8'h24, 32'h0);
			n++;
		end while ((q & m) !== v && n < 100);
		chk("status", q & m, v);
	endtask
	task automatic cmd(input logic [2:0] op, input logic [2:0] b, input logic [14:0] a);
		apb(1'b1, 8'h00, {1'b0, a, 9'h000, b, 1'b0, op});
		// ready alone stays set through bursts and gaps; wait for busy to drop too
		poll(32'h3, 32'h1);
	endtask
	task automatic rdc(input logic [2:0] s, input logic ilv, input logic full);
		logic [63:0] e;
		logic [2:0]  k;
		logic [2:0]  c;
		for (int i = 0; i < 8; i++) begin
			k = 3'(i);
			c = ilv ? (s ^ k) : {s[2] ^ k[2], s[1:0] + k[1:0]};
			e[8*i +: 8] = mem[c];
		end
		cmd(3'h4, 3'h1, {2'h0, full, 9'h000, s});
		poll(32'h8, 32'h8);
		apb(1'b0, 8'h1C, 32'h0);
		chk("rd0", q, e[31:0]);
		if (full) begin
			apb(1'b0, 8'h20, 32'h0);
			chk("rd1", q, e[63:32]);
		end
		apb(1'b1, 8'h24, 32'h8);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test();
	end
	initial begin
		for (int i = 0; i < 8; i++) mem[i] = 8'hA0 + 8'(i);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", {31'h0, se}, 32'h1);
		apb(1'b1, 8'h04, 32'h0120);
		apb(1'b1, 8'h08, 32'h0005);
		apb(1'b1, 8'h0C, 32'h0010);
		apb(1'b1, 8'h10, 32'h0004);
		cmd(3'h1, 3'h0, 15'h0000);
		chk("mr0", {17'h0, mr[0]}, 32'h0020);
		chk("mr1", {17'h0, mr[1]}, 32'h0004);
		chk("mr2", {17'h0, mr[2]}, 32'h0010);
		chk("mr3", {17'h0, mr[3]}, 32'h0004);
		chk("mrvalid", {31'h0, mv}, 32'h1);
		chk("initdone", {31'h0, idn}, 32'h1);
		chk("dllrst", 32'(dr_count), 32'h1);
		cmd(3'h3, 3'h1, 15'h0000);
		apb(1'b1, 8'h14, 32'hA3A2A1A0);
		apb(1'b1, 8'h18, 32'hA7A6A5A4);
		cmd(3'h5, 3'h1, 15'h0003);
		for (int s = 0; s < 8; s++) rdc(3'(s), 1'b0, 1'b1);
		cmd(3'h2, 3'h0, 15'h0008);
		apb(1'b0, 8'h24, 32'h0);
		chk("refused", q & 32'h4, 32'h4);
		apb(1'b1, 8'h24, 32'h4);
		cmd(3'h6, 3'h1, 15'h0000);
		cmd(3'h2, 3'h0, 15'h0008);
		chk("mr0ilv", {17'h0, mr[0]}, 32'h0008);
		cmd(3'h3, 3'h1, 15'h0000);
		for (int s = 0; s < 8; s++) rdc(3'(s), 1'b1, 1'b1);
		cmd(3'h6, 3'h1, 15'h0000);
		cmd(3'h2, 3'h0, 15'h0002);
		cmd(3'h3, 3'h1, 15'h0000);
		apb(1'b1, 8'h14, 32'hB7B6B5B4);
		for (int i = 4; i < 8; i++) mem[i] = 8'hB0 + 8'(i);
		cmd(3'h5, 3'h1, 15'h0006);
		rdc(3'h5, 1'b0, 1'b0);
		rdc(3'h1, 1'b0, 1'b0);
		cmd(3'h6, 3'h1, 15'h0000);
		cmd(3'h2, 3'h0, 15'h0001);
		cmd(3'h3, 3'h1, 15'h0000);
		rdc(3'h2, 1'b0, 1'b1);
		rdc(3'h6, 1'b0, 1'b0);
		chk("errflags", {30'h0, et, es}, 32'h0);
		cmd(3'h1, 3'h0, 15'h0000);
		chk("warm", {31'h0, mv}, 32'h1);
		chk("warm mr0", {17'h0, mr[0]}, 32'h0020);
		chk("warm dll", 32'(dr_count), 32'h2);
		finish_test();
	end
endmodule
